// >>> src/mig_pkg.sv
// Shared constants for the management interrupt gatherer and GPIO data block
package mig_pkg;
	localparam int           ADDR_W       = 8;
	localparam int           DATA_W       = 8;
	localparam logic [7:0]   OFF_STS1     = 8'h08;
	localparam logic [7:0]   OFF_STS2     = 8'h09;
	localparam logic [7:0]   OFF_EN1      = 8'h0A;
	localparam logic [7:0]   OFF_EN2      = 8'h0B;
	localparam logic [7:0]   OFF_GPD1     = 8'h0C;
	localparam logic [7:0]   OFF_GPD2     = 8'h0D;
	localparam logic [7:0]   OFF_GPD3     = 8'h0E;
	localparam logic [7:0]   OFF_GPD4     = 8'h0F;
	localparam logic [7:0]   OFF_DIR1     = 8'h10;
	localparam logic [7:0]   OFF_DIR2     = 8'h11;
	localparam logic [7:0]   OFF_DIR3     = 8'h12;
	localparam logic [7:0]   OFF_DIR4     = 8'h13;
	localparam logic [7:0]   RST_STS1     = 8'h00;
	localparam logic [1:0]   RST_STSGP    = 2'h0;
	localparam logic [7:0]   RST_EN       = 8'h00;
	localparam logic [7:0]   RST_GPD      = 8'h00;
	localparam logic [7:0]   RST_DIR      = 8'hFF;
	localparam logic [7:0]   RST_RD       = 8'h00;
	localparam int           GP2_W        = 5;
	localparam int           BIT_PAR      = 0;
	localparam int           BIT_UART2    = 1;
	localparam int           BIT_UART1    = 2;
	localparam int           BIT_FLOPPY   = 3;
	localparam int           BIT_GPIO_SECOND_BIT3     = 4;
	localparam int           BIT_GPIO_SECOND_BIT4     = 5;
	localparam int           BIT_TO_SIRQ  = 6;
	localparam int           BIT_TO_PIN   = 7;
	localparam int           GP2_SRC_LO   = 3;
endpackage

// >>> src/mig_irq_gather.sv
// Management interrupt gatherer with GPIO data registers
// Overview of operation
// R1: Status2 bits: par, uart2, uart1, floppy, two GPIO
// R2: Status2 bits 3..0 ignore host writes
// R3: Status2 bits 5..4 clear on write one
// R4: Parallel status reads one when port inactive
// R5: Active port: parallel status follows printer acknowledge
// R6: Enable1 bits gate first-group GPIO sources
// R7: Enable2 bits 0..5 gate status2 sources
// R8: Enable2 bit6 routes group to serial IRQ2
// R9: Enable2 bit7 drives group onto low pin
// R10: Data register1 holds first-group lines 0..7
// R11: Data register2 holds five lines, rest reserved
// R12: Data registers 3,4 hold eight lines each
// R13: Reserved bits read back as zero
// R14: Status1 GPIO bits clear on write one
// R15: Group is OR of status AND enable
// R16: Input reads pin; output write sets level
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps

module mig_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,   // Clock
	input  wire logic         rst,   // Async reset
	input  wire logic [W-1:0] d,     // Raw input
	output logic      [W-1:0] q      // Filtered level
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// Level moves only once the last two stages agree
	assign q_nxt = (ff2_r & ff3_r) | (q_r & (ff2_r | ff3_r));
	assign q     = q_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ff1_r <= '0;
			ff2_r <= '0;
			ff3_r <= '0;
			q_r   <= '0;
		end else begin
			ff1_r <= d;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			q_r   <= q_nxt;
		end
	end
endmodule // mig_sync

module mig_irq_gather
	import mig_pkg::*;
(
	input  wire logic              clk,             // 125 MHz clock
	input  wire logic              rst,             // Async reset, high
	input  wire logic [ADDR_W-1:0] addr,            // Register address
	input  wire logic [DATA_W-1:0] wrData,          // Write data
	input  wire logic              wrStb,           // Write strobe
	input  wire logic              rdStb,           // Read strobe
	output logic      [DATA_W-1:0] rdData,          // Read data, next cycle
	input  wire logic              parPortActive,   // Parallel port activated
	input  wire logic              secondUartIrq,   // Second UART interrupt
	input  wire logic              firstUartIrq,    // First UART interrupt
	input  wire logic              floppyIrq,       // Floppy interrupt
	input  wire logic              printerAck,      // Printer acknowledge pin
	input  wire logic [7:0]        gpio1In,         // Group 1 pin levels
	input  wire logic [GP2_W-1:0]  gpio2In,         // Group 2 pin levels
	input  wire logic [7:0]        gpio3In,         // Group 3 pin levels
	input  wire logic [7:0]        gpio4In,         // Group 4 pin levels
	output logic      [7:0]        gpio1Out,        // Group 1 drive level
	output logic      [GP2_W-1:0]  gpio2Out,        // Group 2 drive level
	output logic      [7:0]        gpio3Out,        // Group 3 drive level
	output logic      [7:0]        gpio4Out,        // Group 4 drive level
	output logic      [7:0]        gpio1Oe_n,       // Group 1 enable, low drives
	output logic      [GP2_W-1:0]  gpio2Oe_n,       // Group 2 enable, low drives
	output logic      [7:0]        gpio3Oe_n,       // Group 3 enable, low drives
	output logic      [7:0]        gpio4Oe_n,       // Group 4 enable, low drives
	output logic                   groupMgmtIrq,    // Internal group, high active
	output logic                   serialIrq2Req,   // Request for IRQ2 slot
	output logic                   mgmtIrqPin_n     // Management pin, low active
);
	localparam int SYNC_W = 8 + GP2_W + 8 + 8 + 1;

	logic [SYNC_W-1:0] pinsRaw;
	logic [SYNC_W-1:0] pinsLvl;
	logic [7:0]        gp1Lvl;
	logic [GP2_W-1:0]  gp2Lvl;
	logic [7:0]        gp3Lvl;
	logic [7:0]        gp4Lvl;
	logic              ackLvl;

	assign pinsRaw = {printerAck, gpio4In, gpio3In, gpio2In, gpio1In};

	mig_sync #(
		.W (SYNC_W)
	) u_pinSync (
		.clk (clk),
		.rst (rst),
		.d   (pinsRaw),
		.q   (pinsLvl)
	);

	assign gp1Lvl = pinsLvl[7:0];
	assign gp2Lvl = pinsLvl[8 +: GP2_W];
	assign gp3Lvl = pinsLvl[8 + GP2_W +: 8];
	assign gp4Lvl = pinsLvl[16 + GP2_W +: 8];
	assign ackLvl = pinsLvl[SYNC_W-1];

	// Register decode
	logic wrSts1;
	logic wrSts2;
	logic wrEn1;
	logic wrEn2;
	logic wrGpd1;
	logic wrGpd2;
	logic wrGpd3;
	logic wrGpd4;
	logic wrDir1;
	logic wrDir2;
	logic wrDir3;
	logic wrDir4;

	assign wrSts1 = wrStb && (addr == OFF_STS1);
	assign wrSts2 = wrStb && (addr == OFF_STS2);
	assign wrEn1  = wrStb && (addr == OFF_EN1);
	assign wrEn2  = wrStb && (addr == OFF_EN2);
	assign wrGpd1 = wrStb && (addr == OFF_GPD1);
	assign wrGpd2 = wrStb && (addr == OFF_GPD2);
	assign wrGpd3 = wrStb && (addr == OFF_GPD3);
	assign wrGpd4 = wrStb && (addr == OFF_GPD4);
	assign wrDir1 = wrStb && (addr == OFF_DIR1);
	assign wrDir2 = wrStb && (addr == OFF_DIR2);
	assign wrDir3 = wrStb && (addr == OFF_DIR3);
	assign wrDir4 = wrStb && (addr == OFF_DIR4);

	// GPIO source edges for the sticky status bits
	logic [7:0] gp1Prev_r;
	logic [1:0] gp2Prev_r;
	logic [7:0] gp1Evt;
	logic [1:0] gp2Src;
	logic [1:0] gp2Evt;

	assign gp2Src = gp2Lvl[GP2_SRC_LO +: 2];
	assign gp1Evt = gp1Lvl & ~gp1Prev_r;
	assign gp2Evt = gp2Src & ~gp2Prev_r;

	// Status registers; a new edge beats a clear in the same cycle
	logic [7:0] sts1_r;
	logic [7:0] sts1_nxt;
	logic [1:0] stsGp_r;
	logic [1:0] stsGp_nxt;
	logic [3:0] stsFix;
	logic [7:0] sts2;

	assign sts1_nxt  = (sts1_r & ~(wrSts1 ? wrData : 8'h00)) | gp1Evt;  // R14
	assign stsGp_nxt = (stsGp_r & ~(wrSts2 ? wrData[BIT_GPIO_SECOND_BIT4:BIT_GPIO_SECOND_BIT3] : 2'h0)) | gp2Evt;  // R3
	// Fixed bits are pure wires so no write can touch them
	assign stsFix[BIT_PAR]    = parPortActive ? ackLvl : 1'b1;  // R4 R5
	assign stsFix[BIT_UART2]  = secondUartIrq;  // R2
	assign stsFix[BIT_UART1]  = firstUartIrq;
	assign stsFix[BIT_FLOPPY] = floppyIrq;
	assign sts2 = {2'h0, stsGp_r, stsFix};  // R1 R13

	// Enable registers
	logic [7:0] en1_r;
	logic [7:0] en2_r;

	// GPIO data latches and direction, 1 = input
	logic [7:0]       gpd1_r;
	logic [GP2_W-1:0] gpd2_r;
	logic [7:0]       gpd3_r;
	logic [7:0]       gpd4_r;
	logic [7:0]       dir1_r;
	logic [GP2_W-1:0] dir2_r;
	logic [7:0]       dir3_r;
	logic [7:0]       dir4_r;
	logic [7:0]       gp1Rd;
	logic [7:0]       gp2Rd;
	logic [7:0]       gp3Rd;
	logic [7:0]       gp4Rd;

	assign gp1Rd = (dir1_r & gp1Lvl) | (~dir1_r & gpd1_r);  // R10 R16
	assign gp2Rd = {3'h0, (dir2_r & gp2Lvl) | (~dir2_r & gpd2_r)};  // R11 R13
	assign gp3Rd = (dir3_r & gp3Lvl) | (~dir3_r & gpd3_r);  // R12
	assign gp4Rd = (dir4_r & gp4Lvl) | (~dir4_r & gpd4_r);  // R12

	// Group interrupt
	logic groupIrq;

	assign groupIrq = (|(sts1_r & en1_r)) | (|(sts2[BIT_GPIO_SECOND_BIT4:0] & en2_r[BIT_GPIO_SECOND_BIT4:0]));  // R6 R7 R15

	// Read mux; unmapped addresses read zero
	logic [7:0] rdMux;

	assign rdMux = (addr == OFF_STS1) ? sts1_r :
	               (addr == OFF_STS2) ? sts2 :
	               (addr == OFF_EN1)  ? en1_r :
	               (addr == OFF_EN2)  ? en2_r :
	               (addr == OFF_GPD1) ? gp1Rd :
	               (addr == OFF_GPD2) ? gp2Rd :
	               (addr == OFF_GPD3) ? gp3Rd :
	               (addr == OFF_GPD4) ? gp4Rd :
	               (addr == OFF_DIR1) ? dir1_r :
	               (addr == OFF_DIR2) ? {3'h0, dir2_r} :
	               (addr == OFF_DIR3) ? dir3_r :
	               (addr == OFF_DIR4) ? dir4_r : 8'h00;  // R13

	logic [7:0] rdData_r;
	logic       groupIrq_r;
	logic       serialIrq2_r;
	logic       pin_n_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gp1Prev_r <= RST_STS1;
			gp2Prev_r <= RST_STSGP;
			sts1_r    <= RST_STS1;
			stsGp_r   <= RST_STSGP;
		end else begin
			gp1Prev_r <= gp1Lvl;
			gp2Prev_r <= gp2Src;
			sts1_r    <= sts1_nxt;
			stsGp_r   <= stsGp_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en1_r <= RST_EN;
			en2_r <= RST_EN;
		end else begin
			if (wrEn1) begin
				en1_r <= wrData;
			end
			if (wrEn2) begin
				en2_r <= wrData;
			end
		end
	end

	// Latch always takes the write; it only reaches the pin when output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpd1_r <= RST_GPD;
			gpd2_r <= RST_GPD[GP2_W-1:0];
			gpd3_r <= RST_GPD;
			gpd4_r <= RST_GPD;
		end else begin
			if (wrGpd1) begin
				gpd1_r <= wrData;  // R16
			end
			if (wrGpd2) begin
				gpd2_r <= wrData[GP2_W-1:0];
			end
			if (wrGpd3) begin
				gpd3_r <= wrData;
			end
			if (wrGpd4) begin
				gpd4_r <= wrData;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir1_r <= RST_DIR;
			dir2_r <= RST_DIR[GP2_W-1:0];
			dir3_r <= RST_DIR;
			dir4_r <= RST_DIR;
		end else begin
			if (wrDir1) begin
				dir1_r <= wrData;
			end
			if (wrDir2) begin
				dir2_r <= wrData[GP2_W-1:0];
			end
			if (wrDir3) begin
				dir3_r <= wrData;
			end
			if (wrDir4) begin
				dir4_r <= wrData;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_r     <= RST_RD;
			groupIrq_r   <= 1'b0;
			serialIrq2_r <= 1'b0;
			pin_n_r      <= 1'b1;
		end else begin
			rdData_r     <= rdStb ? rdMux : RST_RD;
			groupIrq_r   <= groupIrq;
			serialIrq2_r <= groupIrq && en2_r[BIT_TO_SIRQ];  // R8
			pin_n_r      <= !(groupIrq && en2_r[BIT_TO_PIN]);  // R9
		end
	end

	assign rdData        = rdData_r;
	assign groupMgmtIrq  = groupIrq_r;
	assign serialIrq2Req = serialIrq2_r;
	assign mgmtIrqPin_n  = pin_n_r;
	assign gpio1Out      = gpd1_r;
	assign gpio2Out      = gpd2_r;
	assign gpio3Out      = gpd3_r;
	assign gpio4Out      = gpd4_r;
	assign gpio1Oe_n     = dir1_r;
	assign gpio2Oe_n     = dir2_r;
	assign gpio3Oe_n     = dir3_r;
	assign gpio4Oe_n     = dir4_r;

	logic rdSts2;

	assign rdSts2 = rdStb && (addr == OFF_STS2);

	a_sts2_map: // R1
	assert property (@(posedge clk) disable iff (rst)
		rdSts2 |=> rdData[BIT_GPIO_SECOND_BIT4:BIT_GPIO_SECOND_BIT3] == $past(stsGp_r) && rdData[BIT_FLOPPY] == $past(floppyIrq))
	else $error("status2 map wrong");

	a_fixed_nowrite: // R2
	assert property (@(posedge clk) disable iff (rst)
		wrSts2 ##2 rdSts2 |=> rdData[BIT_FLOPPY:BIT_UART2] == $past({floppyIrq, firstUartIrq, secondUartIrq}))
	else $error("fixed status bits disturbed by write");

	a_gp_clear: // R3
	assert property (@(posedge clk) disable iff (rst)
		wrSts2 && wrData[BIT_GPIO_SECOND_BIT3] && !gp2Evt[0] |=> !stsGp_r[0])
	else $error("GPIO status not cleared");

	a_gp_keep: // R3
	assert property (@(posedge clk) disable iff (rst)
		stsGp_r[1] && wrSts2 && !wrData[BIT_GPIO_SECOND_BIT4] |=> stsGp_r[1])
	else $error("GPIO status lost on zero write");

	a_par_idle: // R4
	assert property (@(posedge clk) disable iff (rst)
		rdSts2 && !parPortActive |=> rdData[BIT_PAR])
	else $error("parallel status not one while inactive");

	a_par_track: // R5
	assert property (@(posedge clk) disable iff (rst)
		rdSts2 && parPortActive |=> rdData[BIT_PAR] == $past(ackLvl))
	else $error("parallel status not following acknowledge");

	a_en1_gate: // R6
	assert property (@(posedge clk) disable iff (rst)
		(sts1_r & en1_r) != 8'h00 |=> groupMgmtIrq)
	else $error("first enable does not gate source");

	a_en2_gate: // R7
	assert property (@(posedge clk) disable iff (rst)
		floppyIrq && en2_r[BIT_FLOPPY] && en2_r[BIT_TO_PIN] |=> !mgmtIrqPin_n)
	else $error("second enable does not gate source");

	a_sirq_route: // R8
	assert property (@(posedge clk) disable iff (rst)
		!en2_r[BIT_TO_SIRQ] |=> !serialIrq2Req)
	else $error("serial IRQ2 without route enable");

	a_pin_route: // R9
	assert property (@(posedge clk) disable iff (rst)
		mgmtIrqPin_n == !($past(groupIrq) && $past(en2_r[BIT_TO_PIN])))
	else $error("management pin level wrong");

	a_reserved_zero: // R13
	assert property (@(posedge clk) disable iff (rst)
		rdStb && (addr == OFF_GPD2 || addr == OFF_STS2) |=>
		rdData[7:6] == 2'h0 && ($past(addr) == OFF_STS2 || rdData[7:GP2_W] == 3'h0))
	else $error("reserved bits not zero");

	a_sts1_clear: // R14
	assert property (@(posedge clk) disable iff (rst)
		wrSts1 && wrData[0] && !gp1Evt[0] |=> !sts1_r[0])
	else $error("status1 bit not cleared");

	a_group_none: // R15
	assert property (@(posedge clk) disable iff (rst)
		(sts1_r & en1_r) == 8'h00 && (sts2[BIT_GPIO_SECOND_BIT4:0] & en2_r[BIT_GPIO_SECOND_BIT4:0]) == 6'h00 |=> !groupMgmtIrq)
	else $error("group raised with nothing enabled");

	a_gpio_out: // R16
	assert property (@(posedge clk) disable iff (rst)
		wrGpd1 && !dir1_r[0] |=> gpio1Out[0] == $past(wrData[0]) && !gpio1Oe_n[0])
	else $error("output write not driven");
endmodule // mig_irq_gather

// >>> verif/mig_pin_model.sv
// Board side of one GPIO group: resolves each line from block drive and board level
`timescale 1ns/100ps

module mig_pin_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] drv,    // Block drive level
	input  wire logic [W-1:0] oe_n,   // Low while block drives
	input  wire logic [W-1:0] board,  // Level the board applies
	output logic      [W-1:0] pin     // Resolved line level
);
	// Board yields wherever the block drives, so no contention
	assign pin = (drv & ~oe_n) | (board & oe_n);
endmodule // mig_pin_model

// >>> verif/testbench.sv
// Self-checking bench for the management interrupt gatherer and GPIO data block
`timescale 1ns/100ps

module testbench;
	import mig_pkg::*;
	logic       clk, rst, wrStb, rdStb, parPortActive, printerAck;
	logic       secondUartIrq, firstUartIrq, floppyIrq;
	logic       groupMgmtIrq, serialIrq2Req, mgmtIrqPin_n;
	logic [7:0] addr, wrData, rdData, b1, b3, b4, in1, in3, in4, out1, out3, out4, oe1, oe3, oe4;
	logic [4:0] b2, in2, out2, oe2;
	int         mismatches, compares;

	mig_irq_gather i_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .parPortActive(parPortActive), .secondUartIrq(secondUartIrq),
		.firstUartIrq(firstUartIrq), .floppyIrq(floppyIrq), .printerAck(printerAck),
		.gpio1In(in1), .gpio2In(in2), .gpio3In(in3), .gpio4In(in4),
		.gpio1Out(out1), .gpio2Out(out2), .gpio3Out(out3), .gpio4Out(out4),
		.gpio1Oe_n(oe1), .gpio2Oe_n(oe2), .gpio3Oe_n(oe3), .gpio4Oe_n(oe4),
		.groupMgmtIrq(groupMgmtIrq), .serialIrq2Req(serialIrq2Req), .mgmtIrqPin_n(mgmtIrqPin_n));
	mig_pin_model #(.W(8)) i_pin1 (.drv(out1), .oe_n(oe1), .board(b1), .pin(in1));
	mig_pin_model #(.W(5)) i_pin2 (.drv(out2), .oe_n(oe2), .board(b2), .pin(in2));
	mig_pin_model #(.W(8)) i_pin3 (.drv(out3), .oe_n(oe3), .board(b3), .pin(in3));
	mig_pin_model #(.W(8)) i_pin4 (.drv(out4), .oe_n(oe4), .board(b4), .pin(in4));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic give_verdict();
		if (mismatches == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk(rdData, exp);
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Order: group, serial slot, pin (active low)
	task automatic outs(input logic [2:0] e);
		chk({5'h00, groupMgmtIrq, serialIrq2Req, mgmtIrqPin_n}, {5'h00, e});
	endtask

	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		{addr, wrData, wrStb, rdStb, parPortActive, printerAck} = '0;
		{secondUartIrq, firstUartIrq, floppyIrq} = '0;
		{b1, b2, b3, b4} = '0;
		mismatches = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		outs(3'b001);
		rd(OFF_STS2, 8'h01);
		for (logic [7:0] a = OFF_EN1; a <= OFF_GPD4; a++) rd(a, RST_EN);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		parPortActive <= 1'b1;
		printerAck    <= 1'b1;
		waitc(6);
		rd(OFF_STS2, 8'h01);
		printerAck <= 1'b0;
		waitc(6);
		rd(OFF_STS2, 8'h00);
		parPortActive <= 1'b0;
		waitc(2);
		rd(OFF_STS2, 8'h01);
		// Each UART and floppy source, its own gate, then a wrong gate
		for (int i = 1; i < 4; i++) begin
			{floppyIrq, firstUartIrq, secondUartIrq} <= 3'(1 << (i - 1));
			waitc(2);
			rd(OFF_STS2, 8'h01 | 8'(1 << i));
			wr(OFF_STS2, 8'hFF);
			rd(OFF_STS2, 8'h01 | 8'(1 << i));
			wr(OFF_EN2, 8'h40 | 8'(1 << i));
			waitc(2);
			outs(3'b111);
			wr(OFF_EN2, 8'h80 | 8'(1 << (i % 3 + 1)));
			waitc(2);
			outs(3'b001);
		end
		wr(OFF_EN2, 8'h88);
		waitc(2);
		outs(3'b100);
		{floppyIrq, firstUartIrq, secondUartIrq} <= 3'b000;
		wr(OFF_EN2, 8'h81);
		waitc(2);
		outs(3'b100);
		rd(OFF_EN2, 8'h81);
		wr(OFF_EN2, 8'h00);
		b2 <= 5'h18;
		waitc(8);
		rd(OFF_STS2, 8'h31);
		wr(OFF_STS2, 8'h00);
		rd(OFF_STS2, 8'h31);
		wr(OFF_STS2, 8'h10);
		rd(OFF_STS2, 8'h21);
		wr(OFF_EN2, 8'hA0);
		waitc(2);
		outs(3'b100);
		wr(OFF_STS2, 8'h20);
		rd(OFF_STS2, 8'h01);
		waitc(2);
		outs(3'b001);
		wr(OFF_EN2, 8'h80);
		b1 <= 8'h80;
		waitc(8);
		rd(OFF_STS1, 8'h80);
		wr(OFF_EN1, 8'h80);
		waitc(2);
		outs(3'b100);
		wr(OFF_EN1, 8'h7F);
		waitc(2);
		outs(3'b001);
		wr(OFF_STS1, 8'h80);
		rd(OFF_STS1, 8'h00);
		{b1, b2, b3, b4} <= {8'hA5, 5'h1F, 8'h5A, 8'hC3};
		waitc(8);
		rd(OFF_GPD1, 8'hA5);
		rd(OFF_GPD2, 8'h1F);
		rd(OFF_GPD3, 8'h5A);
		rd(OFF_GPD4, 8'hC3);
		wr(OFF_DIR1, 8'hF0);
		wr(OFF_GPD1, 8'h3C);
		wr(OFF_GPD2, 8'hFF);
		wr(OFF_GPD3, 8'h81);
		wr(OFF_GPD4, 8'h7E);
		wr(OFF_DIR2, 8'h00);
		wr(OFF_DIR3, 8'h00);
		wr(OFF_DIR4, 8'h00);
		waitc(2);
		chk(oe1, 8'hF0);
		chk(out3, 8'h81);
		chk({3'h0, out2}, 8'h1F);
		chk(out1, 8'h3C);
		chk(out4, 8'h7E);
		chk({3'h0, oe2}, 8'h00);
		chk(oe3, 8'h00);
		chk(oe4, 8'h00);
		rd(OFF_GPD1, 8'hAC);
		rd(OFF_GPD2, 8'h1F);
		rd(OFF_GPD4, 8'h7E);
		give_verdict();
	end
endmodule // testbench
